// >>> logic/coupled_length_counter_defines.svh
`ifndef COUPLED_LENGTH_COUNTER_DEFINES_SVH
`define COUPLED_LENGTH_COUNTER_DEFINES_SVH

// width of one counter half
`define CLC_NIB_W 4
// reset value of each register and latch
`define CLC_NIB_RST 4'h0
// all-ones value of one half, top of the wrap
`define CLC_NIB_MAX 4'hf
// all-zeros value of one half, bottom of the wrap
`define CLC_NIB_ZERO 4'h0
// single step amount
`define CLC_NIB_ONE 4'h1
// step-by-eight toggles only the weight-eight position
`define CLC_NIB_EIGHT 4'h8
// msb position inside one half
`define CLC_NIB_MSB 3
// latched end value, split (decimal) operation
`define CLC_END_SPLIT 4'he
// latched end value, coupled (logical) operation, high then low
`define CLC_END_COUPLED 8'hfe

`endif

// >>> logic/coupled_length_counter_pkg.sv
`include "coupled_length_counter_defines.svh"

package coupled_length_counter_pkg;

  // one four-position counter value
  typedef logic [`CLC_NIB_W-1:0] nibble_t;

  // how the two halves are linked
  typedef enum logic {
    LINK_SPLIT,
    LINK_COUPLED
  } link_mode_t;

endpackage

// >>> logic/nibble_ctl_if.sv
`timescale 1ns/1ps
`default_nettype none

// control and state of one four-position counter half
interface nibble_ctl_if;
  import coupled_length_counter_pkg::*;

  // from the control side
  logic    load;       // last execution cycle: take length
  nibble_t load_val;   // length field half
  logic    rel_en;     // release gated to register and latch
  logic    count_down; // direction for the coming steps
  logic    step_eight; // toggle weight-eight only
  logic    carry_in;   // carry into the lowest position
  // from the counter
  nibble_t reg_q;      // register value
  nibble_t reg_d;      // register value after this edge
  nibble_t latch_q;    // latch, holds the next register value
  nibble_t latch_d;    // latch value after this edge

  modport ctl (
    output load, load_val, rel_en, count_down, step_eight, carry_in,
    input  reg_q, reg_d, latch_q, latch_d
  );

  modport counter (
    input  load, load_val, rel_en, count_down, step_eight, carry_in,
    output reg_q, reg_d, latch_q, latch_d
  );
endinterface

`default_nettype wire

// >>> logic/length_nibble.sv
`timescale 1ns/1ps
`default_nettype none
`include "coupled_length_counter_defines.svh"

// one four-position up/down counter: register plus leading latch
module length_nibble
  import coupled_length_counter_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       resetn_i,
  // control and state
  nibble_ctl_if.counter   ctl
);

  // incremented or decremented latch value
  nibble_t step_up;
  nibble_t step_dn;
  nibble_t stepped;
  logic    latch_open; // a load or release opens the latch

  // register takes the length, else the latch on a release, else holds
  assign ctl.reg_d = ctl.load   ? ctl.load_val :
                     ctl.rel_en ? ctl.latch_q  : ctl.reg_q; // RULE14

  // wraps modulo sixteen by plain 4-bit arithmetic
  assign step_up = ctl.reg_d + `CLC_NIB_ONE; // RULE13
  assign step_dn = ctl.reg_d - `CLC_NIB_ONE; // RULE13

  // by eight the weight-four carry fires every cycle, so only the msb flips
  assign stepped = ctl.step_eight ? (ctl.reg_d ^ `CLC_NIB_EIGHT) :
                   ctl.count_down ? step_dn : step_up;

  // a closed latch keeps its value, so a held half cannot drift
  assign latch_open  = ctl.load | ctl.rel_en; // RULE14

  // no carry-in: the latch repeats the register value
  assign ctl.latch_d = !latch_open  ? ctl.latch_q :
                       ctl.carry_in ? stepped     : ctl.reg_d; // RULE14

  // register and latch flops
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      ctl.reg_q   <= `CLC_NIB_RST;
      ctl.latch_q <= `CLC_NIB_RST;
    end
    else
    begin
      ctl.reg_q   <= ctl.reg_d;
      ctl.latch_q <= ctl.latch_d;
    end
  end

endmodule

`default_nettype wire

// >>> logic/coupled_length_counter.sv
// Functional notes
// RULE1 - decimal: two halves count with no linkage
// RULE2 - logical: halves joined, high half on top
// RULE3 - coupled span 0-255, up/down by one or eight
// RULE4 - down by eight only block move, transmit
// RULE5 - block move: coupled down, eight if transmit
// RULE6 - high carry-in toggles lsb on each release
// RULE7 - split: high carry-in active whole instruction
// RULE8 - coupled: high carry on low 15 up/0 down
// RULE9 - high carry decoded from low register value
// RULE10 - by eight: low msb toggles every release
// RULE11 - down by eight: carry when low msb reset
// RULE12 - last cycle loads length field, both halves
// RULE13 - each half wraps modulo sixteen
// RULE14 - step only on release, else hold value
// RULE15 - end flag from latch: 1110 or 1111-1110
// RULE16 - controls stable for whole instruction execution
`timescale 1ns/1ps
`default_nettype none
`include "coupled_length_counter_defines.svh"

module coupled_length_counter
  import coupled_length_counter_pkg::*;
(
  // clock and reset
  input  wire logic                   clk_sys_i,
  input  wire logic                   resetn_i,
  // instruction start
  input  wire logic                   last_cycle_i,
  input  wire logic [2*`CLC_NIB_W-1:0] op_length_i,
  // instruction class and stepping controls
  input  wire logic                   logical_op_i,
  input  wire logic                   block_move_instruction_i,
  input  wire logic                   count_down_i,
  input  wire logic                   transmit_mode_i,
  // release gates of the two halves
  input  wire logic                   release_high_i,
  input  wire logic                   release_low_i,
  // counter registers
  output logic [`CLC_NIB_W-1:0]       high_count_o,
  output logic [`CLC_NIB_W-1:0]       low_count_o,
  // counter latches, the value ahead of the registers
  output logic [`CLC_NIB_W-1:0]       high_latch_o,
  output logic [`CLC_NIB_W-1:0]       low_latch_o,
  // end of operation, decoded from the latches
  output logic                        end_of_op_o
);

  // one carrier per half
  nibble_ctl_if high_if ();
  nibble_ctl_if low_if ();

  // controls captured for the instruction being counted
  link_mode_t link_q;      // split or coupled
  link_mode_t link_d;
  logic       down_q;      // count direction
  logic       down_d;
  logic       eight_q;     // step by eight
  logic       eight_d;
  logic       end_q;       // end-of-operation flag
  logic       end_d;

  // decode wires
  logic       coupled_d;         // coupled for the coming steps
  logic       eight_ok;          // block move started in transmit
  logic       low_top_up;        // low register at 15 while up
  logic       low_bottom_dn;     // low register at 0 while down by one
  logic       low_msb_reset;     // low msb clear while down by eight
  logic       carry_high_cpl;    // coupled carry to high lsb
  logic [2*`CLC_NIB_W-1:0] latch_pair_d; // combined latch value

  // block move is always coupled and counted down
  assign coupled_d = logical_op_i | block_move_instruction_i; // RULE2 RULE5

  // only the block move, started in transmit, ever steps by eight
  assign eight_ok  = block_move_instruction_i & transmit_mode_i; // RULE4 RULE5

  // new controls are taken with the length on the last cycle
  assign link_d  = last_cycle_i ? (coupled_d ? LINK_COUPLED : LINK_SPLIT) : link_q;
  assign down_d  = last_cycle_i ? (count_down_i | block_move_instruction_i) : down_q; // RULE5
  assign eight_d = last_cycle_i ? eight_ok : eight_q; // RULE4

  // capture of the instruction controls; holding them protects a count
  // in progress from a control line that moves before the instruction ends
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      link_q  <= LINK_SPLIT;
      down_q  <= 1'b0;
      eight_q <= 1'b0;
    end
    else
    begin
      link_q  <= link_d;
      down_q  <= down_d;
      eight_q <= eight_d;
    end
  end

  // low half: count lines or'ed give a permanent carry-in
  assign low_if.load       = last_cycle_i; // RULE12
  assign low_if.load_val   = op_length_i[`CLC_NIB_W-1:0]; // RULE12
  assign low_if.rel_en     = release_low_i; // RULE14
  assign low_if.count_down = down_d;
  assign low_if.step_eight = eight_d & (link_d == LINK_COUPLED); // RULE10
  assign low_if.carry_in   = 1'b1;

  // the low msb gives no carry out, so the register value is decoded
  assign low_top_up    = ~down_d & (low_if.reg_d == `CLC_NIB_MAX); // RULE8 RULE9
  assign low_bottom_dn = down_d & ~eight_d & (low_if.reg_d == `CLC_NIB_ZERO); // RULE8 RULE9
  assign low_msb_reset = down_d & eight_d & ~low_if.reg_d[`CLC_NIB_MSB]; // RULE11
  assign carry_high_cpl = low_top_up | low_bottom_dn | low_msb_reset; // RULE3

  // high half: carry-in fixed when split, decoded when coupled
  assign high_if.load       = last_cycle_i; // RULE12
  assign high_if.load_val   = op_length_i[2*`CLC_NIB_W-1:`CLC_NIB_W]; // RULE2
  assign high_if.rel_en     = release_high_i; // RULE6 RULE14
  assign high_if.count_down = down_d;
  assign high_if.step_eight = 1'b0; // high half always single steps
  assign high_if.carry_in   = (link_d == LINK_SPLIT) ? 1'b1 : carry_high_cpl; // RULE1 RULE7 RULE8

  // the two counter halves
  length_nibble u_high (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .ctl       (high_if.counter)
  );

  length_nibble u_low (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .ctl       (low_if.counter)
  );

  // end decode taken from the latches, which run one step ahead
  assign latch_pair_d = {high_if.latch_d, low_if.latch_d};
  assign end_d = (link_d == LINK_COUPLED) ? (latch_pair_d == `CLC_END_COUPLED)
                                          : (low_if.latch_d == `CLC_END_SPLIT); // RULE15

  // end flag flop, so the output has no decode glitches
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      end_q <= 1'b0;
    end
    else
    begin
      end_q <= end_d;
    end
  end

  // outputs all come from flops
  assign high_count_o = high_if.reg_q;
  assign low_count_o  = low_if.reg_q;
  assign high_latch_o = high_if.latch_q;
  assign low_latch_o  = low_if.latch_q;
  assign end_of_op_o  = end_q;

  // checks on the counting behaviour
  default clocking chk_cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!resetn_i);

  // a quiet step: both halves released, no new length
  sequence both_step_s;
    release_high_i && release_low_i && !last_cycle_i;
  endsequence

  // up-count by one of the low half from its top value, split or coupled
  sequence low_top_step_s;
    release_low_i && !last_cycle_i && !down_q && !eight_q && low_if.reg_q == 4'hf;
  endsequence

  // length field lands in both registers
  length_load_a: assert property ( // RULE12
    last_cycle_i |=> high_count_o == $past(op_length_i[7:4])
                  && low_count_o == $past(op_length_i[3:0]))
    else $error("length not loaded on last cycle");

  // no release, no change
  low_hold_a: assert property ( // RULE14
    !last_cycle_i && !release_low_i |=> $stable(low_count_o) && $stable(low_latch_o))
    else $error("low half changed without release");

  high_hold_a: assert property ( // RULE14
    !last_cycle_i && !release_high_i |=> $stable(high_count_o))
    else $error("high half changed without release");

  // low half wraps from 15 to 0
  low_wrap_a: assert property ( // RULE13
    low_top_step_s |=> low_count_o == 4'h0)
    else $error("low half did not wrap to zero");

  // split high half steps on every release
  split_step_a: assert property ( // RULE7
    link_q == LINK_SPLIT && release_high_i && !last_cycle_i && !down_q
      |=> high_count_o == $past(high_count_o) + 4'h1)
    else $error("split high half did not step");

  // coupled up: high advances only when low was at 15
  coupled_hold_a: assert property ( // RULE8
    ((link_q == LINK_COUPLED && !down_q) and both_step_s) ##0 low_count_o != 4'hf
      |=> $stable(high_count_o))
    else $error("coupled high half stepped without carry");

  coupled_carry_a: assert property ( // RULE8
    ((link_q == LINK_COUPLED && !down_q) and both_step_s) ##0 low_count_o == 4'hf
      |=> high_count_o == $past(high_count_o) + 4'h1 && low_count_o == 4'h0)
    else $error("coupled carry to high half missing");

  // by eight the low half changes only in its msb
  eight_toggle_a: assert property ( // RULE10
    eight_q && release_low_i && !last_cycle_i
      |=> low_count_o == ($past(low_count_o) ^ 4'h8))
    else $error("step by eight did not toggle low msb");

  // down by eight: carry only when the low msb was clear
  eight_carry_a: assert property ( // RULE11
    (eight_q and both_step_s) ##0 low_count_o[3]
      |=> $stable(high_count_o))
    else $error("down-by-eight carry on wrong cycle");

  // step by eight only for a block move in transmit, always coupled down
  eight_gate_a: assert property ( // RULE4
    eight_q |-> link_q == LINK_COUPLED && down_q)
    else $error("step by eight outside block move");

  block_move_a: assert property ( // RULE5
    last_cycle_i && block_move_instruction_i
      |=> link_q == LINK_COUPLED && down_q && eight_q == $past(transmit_mode_i))
    else $error("block move not coupled down");

  // end flag matches the latches it was decoded from
  end_flag_a: assert property ( // RULE15
    ##1 end_of_op_o == (link_q == LINK_COUPLED ? {high_latch_o, low_latch_o} == 8'hfe
                                               : low_latch_o == 4'he))
    else $error("end of operation flag wrong");

  // coupled single steps with both halves released, by direction
  sequence coupled_up_s;
    link_q == LINK_COUPLED && !down_q && release_high_i && release_low_i && !last_cycle_i;
  endsequence

  sequence coupled_dn_s;
    link_q == LINK_COUPLED && down_q && !eight_q && release_high_i && release_low_i
      && !last_cycle_i;
  endsequence

  // a release copies each latch into its register
  low_latch_lead_a: assert property ( // RULE14
    release_low_i && !last_cycle_i |=> low_count_o == $past(low_latch_o))
    else $error("low register did not take its latch");

  high_latch_lead_a: assert property ( // RULE14
    release_high_i && !last_cycle_i |=> high_count_o == $past(high_latch_o))
    else $error("high register did not take its latch");

  // split: a low release alone leaves the whole high half alone
  split_isolate_a: assert property ( // RULE1
    link_q == LINK_SPLIT && release_low_i && !release_high_i && !last_cycle_i
      |=> $stable(high_count_o) && $stable(high_latch_o))
    else $error("split high half moved with the low half");

  // split down: the high half steps down on every release
  split_down_a: assert property ( // RULE7
    link_q == LINK_SPLIT && release_high_i && !last_cycle_i && down_q
      |=> high_count_o == $past(high_count_o) - 4'h1)
    else $error("split high half did not step down");

  // split up: the low latch stays one step ahead, wrapping at 15
  split_low_lead_a: assert property ( // RULE13
    link_q == LINK_SPLIT && release_low_i && !last_cycle_i && !down_q
      |=> low_latch_o == low_count_o + 4'h1)
    else $error("split low latch not one ahead");

  // coupled: the latch pair runs one full step ahead of the registers
  coupled_up_lead_a: assert property ( // RULE3
    coupled_up_s |=> {high_latch_o, low_latch_o} == {high_count_o, low_count_o} + 8'h01)
    else $error("coupled latch not one above register");

  coupled_dn_lead_a: assert property ( // RULE3
    coupled_dn_s |=> {high_latch_o, low_latch_o} == {high_count_o, low_count_o} - 8'h01)
    else $error("coupled latch not one below register");

  // coupled down by one: high moves only when the low half was zero
  coupled_borrow_a: assert property ( // RULE8
    coupled_dn_s ##0 low_count_o == 4'h0
      |=> high_count_o == $past(high_count_o) - 4'h1 && low_count_o == 4'hf)
    else $error("coupled borrow to high half missing");

  coupled_dn_hold_a: assert property ( // RULE8
    coupled_dn_s ##0 low_count_o != 4'h0 |=> $stable(high_count_o))
    else $error("coupled high half stepped down without borrow");

  // down by eight: the pair drops by eight per release
  eight_lead_a: assert property ( // RULE10
    (eight_q and both_step_s)
      |=> {high_latch_o, low_latch_o} == {high_count_o, low_count_o} - 8'h08)
    else $error("step by eight latch not eight below register");

  // down by eight: the high half borrows when the low msb was clear
  eight_borrow_a: assert property ( // RULE11
    (eight_q and both_step_s) ##0 !low_count_o[3]
      |=> high_count_o == $past(high_count_o) - 4'h1)
    else $error("down-by-eight borrow to high half missing");

endmodule

`default_nettype wire

// >>> test/exec_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none

// execution control sequencer: issues length loads and releases
module exec_ctl_model
  import coupled_length_counter_pkg::*;
(
  // clock
  input  wire logic       clk_sys_i,
  // controls to the counter pair
  output var  logic       last_cycle_o,
  output var  logic [7:0] op_length_o,
  output var  logic       logical_op_o,
  output var  logic       block_move_o,
  output var  logic       count_down_o,
  output var  logic       transmit_mode_o,
  output var  logic       release_high_o,
  output var  logic       release_low_o
);
  // idle at time zero, no load and no release
  initial
  begin
    {last_cycle_o, op_length_o, logical_op_o, block_move_o} = '0;
    {count_down_o, transmit_mode_o, release_high_o, release_low_o} = '0;
  end

  // last cycle; releases stay up to show the load wins
  task automatic load(input logic [7:0] len, input logic lg, bm, dn, tx);
    @(posedge clk_sys_i);
    last_cycle_o <= 1'b1;
    op_length_o <= len;
    {logical_op_o, block_move_o, count_down_o, transmit_mode_o} <= {lg, bm, dn, tx};
    {release_high_o, release_low_o} <= 2'b11;
  endtask

  // one count cycle; controls keep the value of the last load
  task automatic rel(input logic rh, rl);
    @(posedge clk_sys_i);
    last_cycle_o <= 1'b0;
    {release_high_o, release_low_o} <= {rh, rl};
  endtask
endmodule

`default_nettype wire

// >>> test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import coupled_length_counter_pkg::*;
  // clock, reset and the wires between model and counter
  logic       clk_sys_i;
  logic       resetn_i;
  wire        last_cycle, lg, bm, dn, tx, rel_h, rel_l, end_op;
  wire  [7:0] len;
  wire  [3:0] hc, lc, hl, ll;
  // tallies
  int         n_mismatch = 0;
  int         checked = 0;
  // expected registers and latches, high half on top
  logic [7:0] e_reg, e_lat;
  // expected mode and the end flag due after the next edge
  logic       e_cpl, e_dn, e_8, e_end;

  // free-running 125 MHz clock
  initial
  begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  exec_ctl_model u_ctl (
    .clk_sys_i(clk_sys_i), .last_cycle_o(last_cycle), .op_length_o(len),
    .logical_op_o(lg), .block_move_o(bm), .count_down_o(dn),
    .transmit_mode_o(tx), .release_high_o(rel_h), .release_low_o(rel_l)
  );

  coupled_length_counter u_dut (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .last_cycle_i(last_cycle),
    .op_length_i(len), .logical_op_i(lg), .block_move_instruction_i(bm),
    .count_down_i(dn), .transmit_mode_i(tx), .release_high_i(rel_h),
    .release_low_i(rel_l), .high_count_o(hc), .low_count_o(lc),
    .high_latch_o(hl), .low_latch_o(ll), .end_of_op_o(end_op)
  );

  // one step in the current mode; split halves wrap with no linkage
  function automatic logic [7:0] stp(input logic [7:0] v);
    logic [3:0] d;
    d = e_dn ? 4'hf : 4'h1;
    if (e_cpl)
      return v + (e_8 ? 8'hf8 : {{4{e_dn}}, d});
    return {v[7:4] + d, v[3:0] + d};
  endfunction

  // compare and tally
  task automatic cmp(input logic [7:0] got, exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // sample settled outputs; the end flag decodes the latch of the same edge
  task automatic chk;
    @(negedge clk_sys_i);
    e_end = e_cpl ? (e_lat == 8'hfe) : (e_lat[3:0] == 4'he);
    cmp({hc, lc}, e_reg);
    cmp({hl, ll}, e_lat);
    cmp({7'h00, end_op}, {7'h00, e_end});
  endtask

  // load, then update the model; outputs show it one call later
  task automatic ld(input logic [7:0] v, input logic l, b, d, t);
    u_ctl.load(v, l, b, d, t);
    chk();
    e_cpl = l | b;
    e_dn = d | b;
    e_8 = b & t;
    e_reg = v;
    e_lat = stp(v);
  endtask

  // release per half; coupled runs release both halves or neither
  task automatic rl(input logic h, l);
    logic [7:0] n;
    u_ctl.rel(h, l);
    chk();
    n = stp(e_lat);
    if (h)
      {e_reg[7:4], e_lat[7:4]} = {e_lat[7:4], n[7:4]};
    if (l)
      {e_reg[3:0], e_lat[3:0]} = {e_lat[3:0], n[3:0]};
  endtask

  // verdict, the only exit
  task automatic wrap_up;
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // main sequence
  initial
  begin
    resetn_i = 1'b0;
    {e_reg, e_lat, e_cpl, e_dn, e_8, e_end} = '0;
    repeat (10) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    rl(0, 0);
    ld(8'h02, 1, 0, 1, 0);
    repeat (4) rl(1, 1);
    ld(8'h0e, 1, 0, 0, 1);
    rl(1, 1);
    repeat (2) rl(0, 0);
    repeat (2) rl(1, 1);
    ld(8'hfe, 1, 0, 0, 0);
    repeat (3) rl(1, 1);
    ld(8'h3e, 0, 0, 0, 0);
    repeat (2) rl(0, 1);
    rl(1, 0);
    rl(1, 1);
    ld(8'h21, 0, 0, 1, 0);
    repeat (3) rl(1, 1);
    ld(8'h55, 1, 0, 0, 0);
    ld(8'h1f, 0, 1, 0, 1);
    repeat (5) rl(1, 1);
    ld(8'h10, 0, 1, 0, 0);
    repeat (2) rl(1, 1);
    repeat (2) rl(0, 0);
    wrap_up();
  end

  // hang guard, far beyond the short sequence above
  initial
  begin
    #(2000 * 8);
    n_mismatch++;
    wrap_up();
  end
endmodule

`default_nettype wire
